/* pkg/starter_pkg.sv */
// Package with constants, register map and carrier types of the starter delay block.
package starter_pkg;

  // Clock rate and timing.
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned SECOND_NS = 1000000000;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned CYCLES_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned MAINS_CYCLES_PER_SECOND = 60;
  localparam int unsigned DELAY_WIDTH = 7;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] ELAPSED_OFFSET = 8'h08;

  // Control register fields.
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_BYPASS_REQ_BIT = 1;
  localparam int unsigned CTRL_ISOLATION_BIT = 2;
  localparam int unsigned CTRL_DECEL_BIT = 3;
  localparam int unsigned CTRL_EMERGENCY_BIT = 4;
  localparam int unsigned CTRL_AUX1_BIT = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] OUTS_RESET = 32'h0000_0010;

  // Status register fields.
  localparam int unsigned ST_START_PASS_BIT = 0;
  localparam int unsigned ST_AUX_DONE_BIT = 1;
  localparam int unsigned ST_CAP_DONE_BIT = 2;
  localparam int unsigned ST_AT_SPEED_BIT = 3;
  localparam int unsigned ST_FUSE_OK_BIT = 4;
  localparam int unsigned ST_OVERLOAD_OK_BIT = 5;
  localparam int unsigned ST_CPU_EN_BIT = 6;
  localparam int unsigned ST_DUAL_BIT = 7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timer state.
  typedef enum logic [1:0] {
    TMR_IDLE = 2'b00,
    TMR_RUN = 2'b01,
    TMR_DONE = 2'b10
  } tmr_state_t;

  typedef struct packed {
    tmr_state_t st;
    logic [DELAY_WIDTH-1:0] count;
  } timer_t;

  // Switch and jumper settings of one delay.
  typedef struct packed {
    logic cycles_unit;
    logic [DELAY_WIDTH-1:0] value;
  } delay_set_t;

endpackage

/* design/starter_delay_io.sv */
// Start, auxiliary and capacitor delay timers with contactor I/O and AXI4-Lite registers.
//
// Summary of operation
// - Start delay passes start to processor, counting seconds or sixtieth-second cycles.
// - Auxiliary delay times from start command, unit chosen by its own jumper.
// - Capacitor delay runs from bypass closure until capacitor contactor energizes.
// - Every unit selector defaults to seconds when no jumper is fitted.
// - Each delay is an unsigned binary value from seven switch positions.
// - Setting spans 0 to 127, positions weighted 1 through 64.
// - Three separate switch banks set start, auxiliary and capacitor delays.
// - Dual-adjust switch on enables dual ramp, off disables it.
// - Protection jumper fitted holds processor disabled in emergency bypass.
// - Jumper absent keeps processor active in bypass for overload protection.
// - Run output holds main contactor closed through deceleration.
// - At-speed output reports the bypass contactor closed; software commands its closure.
// - Dedicated output energizes and releases the bypass contactor.
// - Dedicated output energizes and releases the inline isolation contactor.
// - At-speed indication comes from the bypass contactor's normally closed auxiliary contact opening.
// - Auxiliary relay one state is reported on a dedicated status output.
// - Auxiliary delay begins counting at the moment of start command.
`timescale 1ns/1ps

module starter_delay_io #(
  parameter int unsigned SECOND_CYCLES = starter_pkg::CYCLES_PER_SECOND
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // Board control inputs.
  input wire logic mains_tick,
  input wire logic start_cmd,
  input wire logic fuse_contact_nc,
  input wire logic overload_contact_nc,
  input wire logic bypass_aux_nc,
  input wire logic emergency_bypass,
  // Switches and jumpers; a jumper input is high when fitted.
  input wire logic dual_adjust_switch,
  input wire logic motor_protection_jumper,
  input wire logic start_unit_select_position,
  input wire logic aux_unit_select_position,
  input wire logic cap_unit_select_position,
  input wire logic [6:0] start_delay_switch_bank,
  input wire logic [6:0] aux_delay_switch_bank,
  input wire logic [6:0] cap_contactor_delay_switch_bank,
  // Outputs to processor and contactors.
  output logic start_to_cpu,
  output logic aux_start_relay,
  output logic cap_contactor,
  output logic dual_ramp_en,
  output logic cpu_enable,
  output logic run_hold_relay,
  output logic at_speed,
  output logic bypass_contactor,
  output logic isolation_contactor,
  output logic aux1_status,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // All state lives in one record, so the clock enable freezes timers, outputs and bus together.
  // Nothing can drift apart while frozen, at the cost of a wide register for every field.
  typedef struct packed {
    logic [31:0] presc;
    logic sec_tick;
    logic cyc_tick;
    starter_pkg::timer_t t_start;
    starter_pkg::timer_t t_aux;
    starter_pkg::timer_t t_cap;
    logic start_prev;
    logic bypass_prev;
    logic [31:0] ctrl;
    logic [31:0] outs;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Steps one delay timer: trigger restarts, zero value fires at once, release clears.
  function automatic starter_pkg::timer_t step_timer(
    input starter_pkg::timer_t t,
    input logic active,
    input logic trigger,
    input starter_pkg::delay_set_t cfg,
    input logic sec_tick,
    input logic cyc_tick
  );
    starter_pkg::timer_t n;
    logic tick;
    n = t;
    tick = cfg.cycles_unit ? cyc_tick : sec_tick;
    if (!active)
    begin
      n.st = starter_pkg::TMR_IDLE;
      n.count = '0;
    end
    // A start held through reset restarts from idle without needing a fresh edge.
    else if (trigger || t.st == starter_pkg::TMR_IDLE)
    begin
      n.count = '0;
      n.st = (cfg.value == '0) ? starter_pkg::TMR_DONE : starter_pkg::TMR_RUN;
    end
    else if (t.st == starter_pkg::TMR_RUN && tick)
    begin
      // The count stops at the setting, so the seven bits never wrap.
      n.count = t.count + 7'h01;
      if (n.count >= cfg.value)
      begin
        n.st = starter_pkg::TMR_DONE;
      end
    end
    return n;
  endfunction

  starter_pkg::delay_set_t start_cfg;
  starter_pkg::delay_set_t aux_cfg;
  starter_pkg::delay_set_t cap_cfg;
  logic start_live;
  logic bypass_closed;
  logic decel;
  logic aw_fire;
  logic w_fire;
  logic wr_go;
  logic rd_go;
  logic [31:0] status_word;

  // Absent jumper reads low, which selects seconds.
  assign start_cfg = {start_unit_select_position, start_delay_switch_bank};
  assign aux_cfg = {aux_unit_select_position, aux_delay_switch_bank};
  assign cap_cfg = {cap_unit_select_position, cap_contactor_delay_switch_bank};

  // A closed contactor opens its normally closed auxiliary contact.
  assign bypass_closed = !bypass_aux_nc;
  assign start_live = start_cmd || s_q.ctrl[starter_pkg::CTRL_START_BIT];
  assign decel = s_q.ctrl[starter_pkg::CTRL_DECEL_BIT];

  // Bus handshakes stay combinational so an address and data may land in either order.
  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign wr_go = (s_q.aw_got || aw_fire) && (s_q.w_got || w_fire) && !s_q.bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  // Live status word shown to software.
  always_comb
  begin
    // Fuse and overload contacts are shown live; they are taken as already synchronous to the clock.
    status_word = 32'h0000_0000;
    status_word[starter_pkg::ST_START_PASS_BIT] = s_q.outs[0];
    status_word[starter_pkg::ST_AUX_DONE_BIT] = s_q.outs[1];
    status_word[starter_pkg::ST_CAP_DONE_BIT] = s_q.outs[2];
    status_word[starter_pkg::ST_AT_SPEED_BIT] = s_q.outs[6];
    status_word[starter_pkg::ST_FUSE_OK_BIT] = fuse_contact_nc;
    status_word[starter_pkg::ST_OVERLOAD_OK_BIT] = overload_contact_nc;
    status_word[starter_pkg::ST_CPU_EN_BIT] = s_q.outs[4];
    status_word[starter_pkg::ST_DUAL_BIT] = s_q.outs[3];
  end

  // Next-state logic for timers, outputs and bus slave.
  always_comb
  begin
    logic [7:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstb;
    waddr = 8'h00;
    wdat = 32'h0000_0000;
    wstb = 4'h0;
    s_d = s_q;
    s_d.sec_tick = 1'b0;
    s_d.cyc_tick = mains_tick;
    // Prescaler free-runs so seconds are whole but the first one may be short.
    if (s_q.presc >= SECOND_CYCLES - 1)
    begin
      s_d.presc = 32'h0000_0000;
      s_d.sec_tick = 1'b1;
    end
    else
    begin
      s_d.presc = s_q.presc + 32'h0000_0001;
    end
    s_d.start_prev = start_live;
    s_d.bypass_prev = bypass_closed;
    // Ticks come from registered copies, so every timer sees each tick exactly once.
    s_d.t_start = step_timer(s_q.t_start, start_live, start_live && !s_q.start_prev,
      start_cfg, s_q.sec_tick, s_q.cyc_tick);
    s_d.t_aux = step_timer(s_q.t_aux, start_live, start_live && !s_q.start_prev,
      aux_cfg, s_q.sec_tick, s_q.cyc_tick);
    s_d.t_cap = step_timer(s_q.t_cap, bypass_closed, bypass_closed && !s_q.bypass_prev,
      cap_cfg, s_q.sec_tick, s_q.cyc_tick);
    // Output bits: start, aux, cap, dual, cpu_en, run, at_speed, bypass, isolation, aux1.
    s_d.outs = 32'h0000_0000;
    s_d.outs[0] = s_q.t_start.st == starter_pkg::TMR_DONE;
    s_d.outs[1] = s_q.t_aux.st == starter_pkg::TMR_DONE;
    s_d.outs[2] = s_q.t_cap.st == starter_pkg::TMR_DONE;
    s_d.outs[3] = dual_adjust_switch;
    s_d.outs[4] = !(s_q.ctrl[starter_pkg::CTRL_EMERGENCY_BIT] || emergency_bypass)
      || !motor_protection_jumper;
    s_d.outs[5] = s_q.outs[0] || decel;
    s_d.outs[6] = bypass_closed;
    s_d.outs[7] = s_q.ctrl[starter_pkg::CTRL_BYPASS_REQ_BIT];
    s_d.outs[8] = s_q.ctrl[starter_pkg::CTRL_ISOLATION_BIT];
    s_d.outs[9] = s_q.ctrl[starter_pkg::CTRL_AUX1_BIT];
    // Write channel.
    if (aw_fire)
    begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (w_fire)
    begin
      s_d.w_got = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (wr_go)
    begin
      waddr = s_q.aw_got ? s_q.aw_addr : s_axi_awaddr;
      wdat = s_q.w_got ? s_q.w_data : s_axi_wdata;
      wstb = s_q.w_got ? s_q.w_strb : s_axi_wstrb;
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = starter_pkg::RESP_OKAY;
      // Only the control word takes data; the read-only words accept and drop it.
      case (waddr)
        starter_pkg::CTRL_OFFSET:
        begin
          for (int i = 0; i < 4; i++)
          begin
            if (wstb[i])
            begin
              s_d.ctrl[i*8 +: 8] = wdat[i*8 +: 8];
            end
          end
        end
        starter_pkg::STATUS_OFFSET, starter_pkg::ELAPSED_OFFSET:
        begin
          s_d.bresp = starter_pkg::RESP_OKAY;
        end
        default:
        begin
          s_d.bresp = starter_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    // Read channel.
    if (rd_go)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = starter_pkg::RESP_OKAY;
      // The elapsed word packs the three counts one byte apart, start lowest.
      case (s_axi_araddr)
        starter_pkg::CTRL_OFFSET: s_d.rdata = s_q.ctrl;
        starter_pkg::STATUS_OFFSET: s_d.rdata = status_word;
        starter_pkg::ELAPSED_OFFSET:
          s_d.rdata = {8'h00, 1'b0, s_q.t_cap.count, 1'b0, s_q.t_aux.count,
            1'b0, s_q.t_start.count};
        default:
        begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = starter_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
  end

  // State register; clock enable freezes everything.
  always_ff @(posedge clk)
  begin
    // Reset acts even while the enable is low, so a frozen block still leaves reset cleanly.
    if (rst)
    begin
      s_q <= '0;
      s_q.ctrl <= starter_pkg::CTRL_RESET;
      // Only the processor enable is set, since no bypass mode is active out of reset.
      s_q.outs <= starter_pkg::OUTS_RESET;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops.
  assign start_to_cpu = s_q.outs[0];
  assign aux_start_relay = s_q.outs[1];
  assign cap_contactor = s_q.outs[2];
  assign dual_ramp_en = s_q.outs[3];
  assign cpu_enable = s_q.outs[4];
  assign run_hold_relay = s_q.outs[5];
  assign at_speed = s_q.outs[6];
  assign bypass_contactor = s_q.outs[7];
  assign isolation_contactor = s_q.outs[8];
  assign aux1_status = s_q.outs[9];
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

endmodule // starter_delay_io

/* tb/starter_delay_io_asserts.sv */
// Port checker of the starter delay block, bound to its top module.
`timescale 1ns/1ps
module starter_delay_io_asserts (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Inputs of the block.
  input wire logic clk_en,
  input wire logic start_cmd,
  input wire logic bypass_aux_nc,
  input wire logic emergency_bypass,
  input wire logic dual_adjust_switch,
  input wire logic motor_protection_jumper,
  input wire logic [6:0] aux_delay_switch_bank,
  // Outputs of the block.
  input wire logic aux_start_relay,
  input wire logic start_to_cpu,
  input wire logic run_hold_relay,
  input wire logic cap_contactor,
  input wire logic dual_ramp_en,
  input wire logic cpu_enable,
  input wire logic at_speed
);
  // One clock domain; reset suspends every check.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // The !rst term keeps the first edge after release from comparing a reset value.
  a_dual_follow: assert property (
    !rst && clk_en |=> dual_ramp_en == $past(dual_adjust_switch))
    else $error("dual ramp enable does not follow its switch");
  a_speed_contact: assert property (
    !rst && clk_en |=> at_speed == !$past(bypass_aux_nc))
    else $error("at speed does not mirror the bypass contact");
  a_cpu_held_off: assert property (
    !rst && clk_en && emergency_bypass && motor_protection_jumper |=> !cpu_enable)
    else $error("processor enabled in bypass with jumper fitted");
  a_cpu_kept_on: assert property (
    !rst && clk_en && !motor_protection_jumper |=> cpu_enable)
    else $error("processor disabled without the jumper");
  a_aux_zero: assert property (
    $rose(start_cmd) && aux_delay_switch_bank == 7'h00 |-> ##[1:3] aux_start_relay)
    else $error("zero auxiliary delay did not fire at once");
  a_aux_needs_start: assert property (
    aux_start_relay |-> $past(start_cmd) || $past(start_cmd, 2) || $past(start_cmd, 3))
    else $error("auxiliary relay without a start command");
  a_cap_needs_bypass: assert property (
    cap_contactor |-> !$past(bypass_aux_nc) || !$past(bypass_aux_nc, 2)
      || !$past(bypass_aux_nc, 3))
    else $error("capacitor contactor without bypass closed");
  a_run_hold: assert property (start_to_cpu |-> ##[0:1] run_hold_relay)
    else $error("run hold missing while start is passed");
endmodule // starter_delay_io_asserts

bind starter_delay_io starter_delay_io_asserts checker_inst (
  .clk, .rst, .clk_en, .start_cmd, .bypass_aux_nc, .emergency_bypass, .dual_adjust_switch,
  .motor_protection_jumper, .aux_delay_switch_bank, .aux_start_relay, .start_to_cpu,
  .run_hold_relay, .cap_contactor, .dual_ramp_en, .cpu_enable, .at_speed
);

/* tb/contactor_model.sv */
// Partner model: mains cycle ticks and the bypass contactor with its auxiliary contact.
`timescale 1ns/1ps
module contactor_model #(
  parameter int TICK = 8,
  parameter int LAT = 3
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Coil drive from the block.
  input wire logic bypass_coil,
  // Contact and tick back to the block.
  output logic bypass_aux_nc,
  output logic mains_tick
);
  int cnt = 0;
  logic [7:0] coil_q = 8'h00;
  // The supply ticks whatever the starter does; the armature lags its coil by LAT cycles.
  always @(posedge clk)
  begin
    cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
    mains_tick <= !rst && cnt == TICK - 1;
    coil_q <= {coil_q[6:0], bypass_coil && !rst};
  end
  // A closed contactor opens its normally closed auxiliary contact.
  assign bypass_aux_nc = !coil_q[LAT - 1];
endmodule // contactor_model

/* tb/starter_delay_io_bench.sv */
// Self-checking bench of the starter delay timers and contactor outputs.
`timescale 1ns/1ps
module starter_delay_io_bench;
  localparam int SEC = 20;
  localparam int TICK = 8;
  // Stimulus, quiet at time zero; contacts start healthy.
  logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, start_cmd = 1'b0, emergency_bypass = 1'b0;
  logic dual_adjust_switch = 1'b0, motor_protection_jumper = 1'b0;
  logic fuse_contact_nc = 1'b1, overload_contact_nc = 1'b1;
  logic start_unit_select_position = 1'b0, aux_unit_select_position = 1'b0;
  logic cap_unit_select_position = 1'b0;
  logic [6:0] start_delay_switch_bank = 7'h00, aux_delay_switch_bank = 7'h00;
  logic [6:0] cap_contactor_delay_switch_bank = 7'h00;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  // Block outputs and partner contacts.
  logic mains_tick, bypass_aux_nc, start_to_cpu, aux_start_relay, cap_contactor, dual_ramp_en;
  logic cpu_enable, run_hold_relay, at_speed, bypass_contactor, isolation_contactor, aux1_status;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int mismatches = 0;
  int total_checks = 0;

  // A short second keeps the seconds mode testable.
  starter_delay_io #(.SECOND_CYCLES(SEC)) dut (.*);
  contactor_model #(.TICK(TICK)) partner (
    .clk, .rst, .bypass_coil(bypass_contactor), .bypass_aux_nc, .mains_tick);

  // Free-running 200 MHz clock.
  always #2.5 clk = !clk;

  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  // One write; each channel is released at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("write response", {30'h0, r}, {30'h0, s_axi_bresp});
  endtask

  // One read; data and response are judged at the edge that takes them.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("read data", e, s_axi_rdata);
    chk("read response", {30'h0, r}, {30'h0, s_axi_rresp});
  endtask

  // Reset values, a write to a read-only place and an unmapped address.
  task automatic t_reset;
    rd(starter_pkg::CTRL_OFFSET, starter_pkg::CTRL_RESET, starter_pkg::RESP_OKAY);
    rd(starter_pkg::STATUS_OFFSET, 32'h70, starter_pkg::RESP_OKAY);
    rd(starter_pkg::ELAPSED_OFFSET, 32'h0, starter_pkg::RESP_OKAY);
    rd(8'h0C, 32'h0, starter_pkg::RESP_SLVERR);
    wr(starter_pkg::STATUS_OFFSET, 32'hFFFF_FFFF, starter_pkg::RESP_OKAY);
    rd(starter_pkg::STATUS_OFFSET, 32'h70, starter_pkg::RESP_OKAY);
    wr(8'h0C, 32'hFFFF_FFFF, starter_pkg::RESP_SLVERR);
    rd(starter_pkg::CTRL_OFFSET, starter_pkg::CTRL_RESET, starter_pkg::RESP_OKAY);
  endtask

  // Start and auxiliary timers from one start command, judged early and late.
  task automatic t_timers(input logic [6:0] sv, input logic su, input logic [6:0] av,
                          input logic au, input int lo, input int hi);
    @(posedge clk);
    start_delay_switch_bank <= sv;
    start_unit_select_position <= su;
    aux_delay_switch_bank <= av;
    aux_unit_select_position <= au;
    @(posedge clk);
    start_cmd <= 1'b1;
    repeat (lo) @(posedge clk);
    chk("start early", 32'h0, start_to_cpu);
    chk("aux early", {31'h0, av == 7'h00}, aux_start_relay);
    repeat (hi - lo) @(posedge clk);
    chk("start", 32'h1, start_to_cpu);
    chk("aux", 32'h1, aux_start_relay);
    start_cmd <= 1'b0;
    repeat (4) @(posedge clk);
    chk("start off", 32'h0, start_to_cpu);
  endtask

  // Bypass closure starts the capacitor delay; software drives the contactors.
  task automatic t_bypass;
    @(posedge clk);
    cap_contactor_delay_switch_bank <= 7'h02;
    cap_unit_select_position <= 1'b1;
    dual_adjust_switch <= 1'b1;
    wr(starter_pkg::CTRL_OFFSET, 32'h2E, starter_pkg::RESP_OKAY);
    repeat (8) @(posedge clk);
    chk("bypass", 32'h1, bypass_contactor);
    chk("isolation", 32'h1, isolation_contactor);
    chk("aux1", 32'h1, aux1_status);
    chk("decel hold", 32'h1, run_hold_relay);
    chk("at speed", 32'h1, at_speed);
    chk("cap early", 32'h0, cap_contactor);
    repeat (22) @(posedge clk);
    chk("cap", 32'h1, cap_contactor);
    rd(starter_pkg::STATUS_OFFSET, 32'hFC, starter_pkg::RESP_OKAY);
    wr(starter_pkg::CTRL_OFFSET, 32'h0, starter_pkg::RESP_OKAY);
    repeat (10) @(posedge clk);
    chk("bypass off", 32'h0, bypass_contactor);
    chk("isolation off", 32'h0, isolation_contactor);
    chk("cap off", 32'h0, cap_contactor);
    chk("hold off", 32'h0, run_hold_relay);
  endtask

  // Opened contacts, emergency bypass with and without the jumper, software bypass, frozen enable.
  task automatic t_guard;
    @(posedge clk);
    fuse_contact_nc <= 1'b0;
    overload_contact_nc <= 1'b0;
    emergency_bypass <= 1'b1;
    motor_protection_jumper <= 1'b1;
    dual_adjust_switch <= 1'b0;
    repeat (3) @(posedge clk);
    chk("cpu enable", 32'h0, cpu_enable);
    rd(starter_pkg::STATUS_OFFSET, 32'h0, starter_pkg::RESP_OKAY);
    motor_protection_jumper <= 1'b0;
    repeat (3) @(posedge clk);
    chk("cpu kept", 32'h1, cpu_enable);
    chk("dual off", 32'h0, dual_ramp_en);
    motor_protection_jumper <= 1'b1;
    emergency_bypass <= 1'b0;
    wr(starter_pkg::CTRL_OFFSET, 32'h10, starter_pkg::RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("cpu by software", 32'h0, cpu_enable);
    clk_en <= 1'b0;
    dual_adjust_switch <= 1'b1;
    repeat (3) @(posedge clk);
    chk("frozen dual", 32'h0, dual_ramp_en);
    clk_en <= 1'b1;
    repeat (2) @(posedge clk);
    chk("dual on", 32'h1, dual_ramp_en);
  endtask

  // Verdict and end of the run.
  task automatic results;
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence after five reset cycles.
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_timers(7'h7F, 1'b1, 7'h00, 1'b0, 1000, 1024);
    t_timers(7'h02, 1'b0, 7'h05, 1'b1, 19, 46);
    t_bypass();
    t_guard();
    results();
  end

  // The tests need about 1200 cycles; a hang is cut well beyond that.
  initial
  begin
    #(5000 * 5);
    mismatches++;
    results();
  end
endmodule // starter_delay_io_bench
